// ### dpc_pkg.sv
// constants for the dual loop core clock source control block
// assumes one bus clock domain at 200 MHz and a single control word
package dpc_pkg;

    // register map and field positions of the control word
    localparam int          ADDR_W         = 8;
    localparam logic [7:0]  CTRL_ADDR      = 8'h00;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
    localparam int          STRAP_CFG_LSB  = 0;
    localparam int          STRAP_RNG_LSB  = 5;
    localparam int          SECOND_RNG_LSB = 7;
    localparam int          SECOND_CFG_LSB = 9;
    localparam int          SELECT_BIT     = 14;
    localparam int          STATUS_BIT     = 15;
    localparam int          FIRST_CFG_LSB  = 16;
    localparam int          FIRST_INT_BIT  = 21;
    localparam int          FIRST_RNG_LSB  = 22;

    // range encodings
    localparam logic [1:0] RNG_HIGH = 2'h0;
    localparam logic [1:0] RNG_LOW  = 2'h2;

    // multiplier encodings
    localparam logic [4:0] CFG_OFF_LO  = 5'h01;
    localparam logic [4:0] CFG_BYP_LO  = 5'h02;
    localparam logic [4:0] CFG_BYP_HI  = 5'h03;
    localparam logic [4:0] CFG_HALF_LO = 5'h04;
    localparam logic [4:0] CFG_HALF_HI = 5'h14;
    localparam logic [4:0] CFG_OFF_HI  = 5'h1f;

    // timing
    localparam int CLK_MHZ        = 200;
    localparam int SWITCH_MAX_CYC = 3;

    typedef enum logic [1:0] {
        DPC_OFF    = 2'b00,
        DPC_BYPASS = 2'b01,
        DPC_RUN    = 2'b10
    } dpc_mode_t;

    typedef enum logic [1:0] {
        DPC_SW_IDLE = 2'b00,
        DPC_SW_GATE = 2'b01,
        DPC_SW_OPEN = 2'b10
    } dpc_sw_t;

endpackage : dpc_pkg

// ### dpc_mult_decode.sv
// multiplier field decoder for one loop
// assumes a stable five bit code; purely combinational
`timescale 1ns/100ps
`default_nettype none

module dpc_mult_decode
    import dpc_pkg::*;
(
    input  wire logic [4:0] cfg,
    output var dpc_mode_t   mode,
    output logic            half
);

    // off, bypass, or running; odd codes in the low band are half steps
    always_comb
    begin
        if (cfg <= CFG_OFF_LO || cfg == CFG_OFF_HI)
            mode = DPC_OFF;
        else if (cfg == CFG_BYP_LO || cfg == CFG_BYP_HI)
            mode = DPC_BYPASS;
        else
            mode = DPC_RUN;
        half = (cfg >= CFG_HALF_LO) && (cfg <= CFG_HALF_HI) && cfg[0];
    end

endmodule : dpc_mult_decode
`default_nettype wire

// ### dpc_lock_timer.sv
// lock wait counter for one loop
// assumes the code and range come from registers in the mclk domain
`timescale 1ns/100ps
`default_nettype none

module dpc_lock_timer
    import dpc_pkg::*;
#(
    parameter int unsigned LOCK_CYC = 20000
)
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [4:0] cfg,
    input  wire logic [1:0] rng,
    input  wire dpc_mode_t  mode,
    output logic            locked
);
    localparam int CW = $clog2(LOCK_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(LOCK_CYC);

    logic [CW-1:0] cnt;
    logic [6:0]    last_set;

    // any change of setting restarts the wait; a stopped loop never locks
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt      <= '0;
            last_set <= 7'h00;
            locked   <= 1'b0;
        end
        else
        begin
            last_set <= {rng, cfg};
            if (mode != DPC_RUN || {rng, cfg} != last_set)
            begin
                cnt    <= '0;
                locked <= 1'b0;
            end
            else if (cnt != LAST)
                cnt <= cnt + 1'b1;
            else
                locked <= 1'b1;
        end
    end

endmodule : dpc_lock_timer
`default_nettype wire

// ### dpc_clock_select.sv
// core clock source control for a two loop clock generator
// assumes a plain register port in the mclk domain and strap pins that
// are stable while reset is held; loop clocks are gated outside
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

module dpc_clock_select
    import dpc_pkg::*;
#(
    parameter int unsigned LOCK_TIME_NS = 100000
)
(
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [31:0]       wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [31:0]       rdata,
    input  wire logic [4:0]        ratio_strap_pins,
    input  wire logic [1:0]        range_strap_pins,
    output logic      [1:0][4:0]   pll_ratio,
    output logic      [1:0][1:0]   pll_range,
    output logic      [1:0]        pll_high_band,
    output logic      [1:0]        pll_enable,
    output logic      [1:0]        pll_locked,
    output logic      [1:0]        core_gate,
    output logic                   core_bypass,
    output logic                   core_clock_off,
    output logic                   bus_one_to_one,
    output logic      [4:0]        core_to_bus_ratio,
    output logic                   pll_source_status
);
    localparam int unsigned LOCK_CYC = (LOCK_TIME_NS * CLK_MHZ + 999) / 1000;

    logic            rst_meta;
    logic            rst_q;
    logic            strap_taken;
    logic [4:0]      strap_cfg;
    logic [1:0]      strap_rng;
    logic [1:0]      second_pll_range;
    logic [4:0]      second_pll_ratio;
    logic            pll_source_select;
    logic [4:0]      first_pll_ratio;
    logic            first_pll_internal_ctrl;
    logic [1:0]      first_pll_range;
    logic [1:0][4:0] eff_cfg;
    logic [1:0][1:0] eff_rng;
    dpc_mode_t       mode [2];
    logic [1:0]      half;
    logic [1:0]      lock_now;
    dpc_sw_t         sw_state;
    logic            active;
    logic            ctrl_hit;
    logic [31:0]     ctrl_word;

    ////////////////////////////////////////////////////////////////////
    // reset release and strap capture

    // release through two flops so no flop past the pair sees a raw deassertion
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta <= 1'b0;
            rst_q    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_q    <= rst_meta;
        end
    end

    // straps caught once after release; later pin motion needs a new reset
    always_ff @(posedge mclk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            strap_taken <= 1'b0;
            strap_cfg   <= 5'h00;
            strap_rng   <= 2'h0;
        end
        else if (!strap_taken)
        begin
            strap_taken <= 1'b1;
            strap_cfg   <= ratio_strap_pins;
            strap_rng   <= range_strap_pins;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control word

    assign ctrl_hit = (addr == CTRL_ADDR);

    // writable fields; reset leaves all of them zero
    always_ff @(posedge mclk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            second_pll_range        <= 2'h0;
            second_pll_ratio        <= 5'h00;
            pll_source_select       <= 1'b0;
            first_pll_ratio         <= 5'h00;
            first_pll_internal_ctrl <= 1'b0;
            first_pll_range         <= 2'h0;
        end
        else if (wr && ctrl_hit)
        begin
            second_pll_range        <= wdata[SECOND_RNG_LSB +: 2];
            second_pll_ratio        <= wdata[SECOND_CFG_LSB +: 5];
            pll_source_select       <= wdata[SELECT_BIT];
            first_pll_ratio         <= wdata[FIRST_CFG_LSB +: 5];
            first_pll_internal_ctrl <= wdata[FIRST_INT_BIT];
            first_pll_range         <= wdata[FIRST_RNG_LSB +: 2];
        end
    end

    // read view; straps sit in the low bits, reserved bits read zero
    always_comb
    begin
        ctrl_word                       = CTRL_RESET;
        ctrl_word[STRAP_CFG_LSB +: 5]   = strap_cfg;
        ctrl_word[STRAP_RNG_LSB +: 2]   = strap_rng;
        ctrl_word[SECOND_RNG_LSB +: 2]  = second_pll_range;
        ctrl_word[SECOND_CFG_LSB +: 5]  = second_pll_ratio;
        ctrl_word[SELECT_BIT]           = pll_source_select;
        ctrl_word[STATUS_BIT]           = pll_source_status;
        ctrl_word[FIRST_CFG_LSB +: 5]   = first_pll_ratio;
        ctrl_word[FIRST_INT_BIT]        = first_pll_internal_ctrl;
        ctrl_word[FIRST_RNG_LSB +: 2]   = first_pll_range;
    end

    // read data stand one cycle; unmapped reads answer zero
    always_ff @(posedge mclk or negedge rst_q)
    begin
        if (!rst_q)
            rdata <= 32'h0000_0000;
        else if (rd && ctrl_hit)
            rdata <= ctrl_word;
        else
            rdata <= 32'h0000_0000;
    end

    ////////////////////////////////////////////////////////////////////
    // per loop setting, decode, lock wait and outputs

    // first loop follows the straps until internal control is set
    always_comb
    begin
        eff_cfg[0] = first_pll_internal_ctrl ? first_pll_ratio
                                             : strap_cfg;
        eff_rng[0] = first_pll_internal_ctrl ? first_pll_range : strap_rng;
        eff_cfg[1] = second_pll_ratio;
        eff_rng[1] = second_pll_range;
    end

    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_pll
            dpc_mult_decode u_dec (
                .cfg  (eff_cfg[i]),
                .mode (mode[i]),
                .half (half[i])
            );

            dpc_lock_timer #(
                .LOCK_CYC (LOCK_CYC)
            ) u_lock (
                .mclk   (mclk),
                .rst_n  (rst_q),
                .cfg    (eff_cfg[i]),
                .rng    (eff_rng[i]),
                .mode   (mode[i]),
                .locked (lock_now[i])
            );

            // loop enable only in run codes; bypass and off stop it
            always_ff @(posedge mclk or negedge rst_q)
            begin
                if (!rst_q)
                begin
                    pll_ratio[i]     <= 5'h00;
                    pll_range[i]     <= 2'h0;
                    pll_high_band[i] <= 1'b0;
                    pll_enable[i]    <= 1'b0;
                    pll_locked[i]    <= 1'b0;
                end
                else
                begin
                    pll_ratio[i]     <= eff_cfg[i];
                    pll_range[i]     <= eff_rng[i];
                    pll_high_band[i] <= (eff_rng[i] == RNG_HIGH);
                    pll_enable[i]    <= (mode[i] == DPC_RUN);
                    pll_locked[i]    <= lock_now[i];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // source changeover

    // break before make: both gates drop for one cycle, so no runt pulse;
    // no lock check here, keeping the way back to a locked loop fast
    always_ff @(posedge mclk or negedge rst_q)
    begin
        if (!rst_q)
            sw_state <= DPC_SW_IDLE;
        else
            unique case (sw_state)
                DPC_SW_IDLE:
                    if (pll_source_select != active)
                        sw_state <= DPC_SW_GATE;
                DPC_SW_GATE:
                    sw_state <= DPC_SW_OPEN;
                DPC_SW_OPEN:
                    sw_state <= DPC_SW_IDLE;
                default:
                    sw_state <= DPC_SW_IDLE;
            endcase
    end

    // new source and status take effect together, 2 cycles after write
    always_ff @(posedge mclk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            active            <= 1'b0;
            pll_source_status <= 1'b0;
        end
        else if (sw_state == DPC_SW_GATE)
        begin
            active            <= pll_source_select;
            pll_source_status <= pll_source_select;
        end
    end

    // core clock gates per loop
    always_ff @(posedge mclk or negedge rst_q)
    begin
        if (!rst_q)
            core_gate <= 2'b01;
        else if (sw_state == DPC_SW_IDLE && pll_source_select != active)
            core_gate <= 2'b00;
        else if (sw_state == DPC_SW_GATE)
            core_gate <= pll_source_select ? 2'b10 : 2'b01;
    end

    // core mode follows the loop in use
    always_ff @(posedge mclk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            core_bypass       <= 1'b0;
            core_clock_off    <= 1'b0;
            bus_one_to_one    <= 1'b0;
            core_to_bus_ratio <= 5'h00;
        end
        else
        begin
            core_bypass       <= (mode[active] == DPC_BYPASS);
            bus_one_to_one    <= (mode[active] == DPC_BYPASS);
            core_clock_off    <= (mode[active] == DPC_OFF);
            core_to_bus_ratio <= eff_cfg[active];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    sequence s_sel_moved;
        $changed(pll_source_select) && sw_state == DPC_SW_IDLE;
    endsequence

    sequence s_gates_dark;
        core_gate == 2'b00;
    endsequence

    property p_reset_clear;
        @(posedge mclk) $rose(rst_q) |-> !pll_source_select
            && !first_pll_internal_ctrl && second_pll_ratio == 5'h00;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("control bits not clear after reset");

    property p_strap_read;
        @(posedge mclk) disable iff (!rst_q)
            rd && ctrl_hit |=> rdata[6:0] == {strap_rng, strap_cfg};
    endproperty
    a_strap_read: assert property (p_strap_read)
        else $error("strap bits not shown on read");

    property p_second_internal;
        @(posedge mclk) disable iff (!rst_q)
            ##1 pll_ratio[1] == $past(second_pll_ratio);
    endproperty
    a_second_internal: assert property (p_second_internal)
        else $error("second loop not set by its register field");

    property p_second_off;
        @(posedge mclk) disable iff (!rst_q)
            $rose(rst_q) ##1 1'b1 |-> !pll_enable[1];
    endproperty
    a_second_off: assert property (p_second_off)
        else $error("second loop running after reset");

    property p_switch_time;
        @(posedge mclk) disable iff (!rst_q)
            s_sel_moved |-> ##1 s_gates_dark ##1
                (pll_source_status == $past(pll_source_select, 2));
    endproperty
    a_switch_time: assert property (p_switch_time)
        else $error("changeover late or wrong");

    property p_status_gate;
        @(posedge mclk) disable iff (!rst_q)
            sw_state == DPC_SW_IDLE |->
                core_gate == (pll_source_status ? 2'b10 : 2'b01);
    endproperty
    a_status_gate: assert property (p_status_gate)
        else $error("status disagrees with gated source");

    property p_no_overlap;
        @(posedge mclk) disable iff (!rst_q)
            core_gate != 2'b11;
    endproperty
    a_no_overlap: assert property (p_no_overlap)
        else $error("both loops gated to core");

    property p_first_off;
        @(posedge mclk) disable iff (!rst_q)
            first_pll_internal_ctrl && first_pll_ratio == 5'h00
                |=> !pll_enable[0] ##1 !pll_locked[0];
    endproperty
    a_first_off: assert property (p_first_off)
        else $error("first loop still running when set off");

    property p_bypass;
        @(posedge mclk) disable iff (!rst_q)
            mode[active] == DPC_BYPASS |=> core_bypass && bus_one_to_one;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass not applied to core");

    property p_clock_off;
        @(posedge mclk) disable iff (!rst_q)
            mode[active] == DPC_OFF |=> core_clock_off && !core_bypass;
    endproperty
    a_clock_off: assert property (p_clock_off)
        else $error("core clock not stopped for off code");

endmodule : dpc_clock_select
`default_nettype wire

// ### dpc_clock_select_bench.sv
// self-checking bench for the core clock source control block
// assumes the design files and dpc_pkg are compiled first; the bench alone
// drives every input and checks the register port and the clock controls
`timescale 1ns/100ps
`default_nettype none

module dpc_clock_select_bench
    import dpc_pkg::*;
;

`define CHK(nm, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got); \
            bad_count++; \
        end \
    end

    logic              mclk;
    logic              rst_n;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
    logic [31:0]       rdata;
    logic [4:0]        ratio_strap_pins;
    logic [1:0]        range_strap_pins;
    logic [1:0][4:0]   pll_ratio;
    logic [1:0][1:0]   pll_range;
    logic [1:0]        pll_high_band;
    logic [1:0]        pll_enable;
    logic [1:0]        pll_locked;
    logic [1:0]        core_gate;
    logic              core_bypass;
    logic              core_clock_off;
    logic              bus_one_to_one;
    logic [4:0]        core_to_bus_ratio;
    logic              pll_source_status;
    int                bad_count;
    int                tests_run;
    logic [31:0]       rv;
    logic [31:0]       strap;

    // short lock time keeps the run small: 50 ns is 10 cycles
    dpc_clock_select #(.LOCK_TIME_NS(50)) dut (
        .mclk              (mclk),
        .rst_n             (rst_n),
        .addr              (addr),
        .wdata             (wdata),
        .wr                (wr),
        .rd                (rd),
        .rdata             (rdata),
        .ratio_strap_pins  (ratio_strap_pins),
        .range_strap_pins  (range_strap_pins),
        .pll_ratio         (pll_ratio),
        .pll_range         (pll_range),
        .pll_high_band     (pll_high_band),
        .pll_enable        (pll_enable),
        .pll_locked        (pll_locked),
        .core_gate         (core_gate),
        .core_bypass       (core_bypass),
        .core_clock_off    (core_clock_off),
        .bus_one_to_one    (bus_one_to_one),
        .core_to_bus_ratio (core_to_bus_ratio),
        .pll_source_status (pll_source_status)
    );

    ////////////////////////////////////////////////////////////////////////
    // clock and control word packing

    always #2.5 mclk = ~mclk;

    // fields: range1 8:7, ratio1 13:9, select 14, ratio0 20:16,
    // internal ctrl 21, range0 23:22
    function automatic logic [31:0] mk(input logic [1:0] r1,
                                       input logic [4:0] c1,
                                       input logic       s,
                                       input logic [4:0] c0,
                                       input logic       i0,
                                       input logic [1:0] r0);
        mk = {8'h00, r0, i0, c0, 1'b0, s, c1, r1, 7'h00};
    endfunction : mk

    ////////////////////////////////////////////////////////////////////////
    // bus tasks

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    // let n edges pass, then step off the edge so outputs are settled
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : wait_cyc

    // reset with new straps; requests wait for the synchroniser
    task automatic do_reset(input logic [4:0] c, input logic [1:0] r);
        @(posedge mclk);
        rst_n            <= 1'b0;
        ratio_strap_pins <= c;
        range_strap_pins <= r;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (6) @(posedge mclk);
        strap = {25'h0, r, c};
    endtask : do_reset

    // bounded wait for a loop to report lock
    task automatic wait_lock(input int idx);
        int n;
        n = 0;
        while (pll_locked[idx] !== 1'b1 && n < 100)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        `CHK("lock wait", 1'b1, pll_locked[idx])
    endtask : wait_lock

    // write the select and watch the gate through the changeover
    task automatic switch_to(input logic [31:0] w, input logic s);
        logic glitch;
        logic dark;
        glitch = 1'b0;
        dark = 1'b0;
        wr_reg(CTRL_ADDR, w);
        repeat (SWITCH_MAX_CYC)
        begin
            @(posedge mclk);
            #1;
            if (core_gate === 2'b11)
                glitch = 1'b1;
            if (core_gate === 2'b00)
                dark = 1'b1;
        end
        `CHK("gate overlap", 1'b0, glitch)
        `CHK("gate dark", 1'b1, dark)
        `CHK("core_gate", (s ? 2'b10 : 2'b01), core_gate)
        `CHK("source status", s, pll_source_status)
    endtask : switch_to

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////
    // watchdog: the sequence needs well under 2000 cycles

    initial
    begin
        #20000;
        bad_count++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence

    initial
    begin
        mclk = 1'b0;
        rst_n = 1'b0;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        ratio_strap_pins = 5'h00;
        range_strap_pins = 2'h0;
        bad_count = 0;
        tests_run = 0;
        do_reset(5'h0c, RNG_LOW);
        rd_reg(CTRL_ADDR, rv);
        `CHK("reset word", strap, rv)
        `CHK("ratio0 strap", 5'h0c, pll_ratio[0])
        `CHK("band0 low", 1'b0, pll_high_band[0])
        `CHK("gate first", 2'b01, core_gate)
        `CHK("core ratio", 5'h0c, core_to_bus_ratio)
        `CHK("clock on", 1'b0, core_clock_off)
        `CHK("loop1 off", 1'b0, pll_enable[1])
        `CHK("loop1 range", 2'h0, pll_range[1])
        wait_lock(0);
        // read-only bits and the top byte must ignore the ones written
        wr_reg(CTRL_ADDR, mk(RNG_HIGH, 5'h15, 1'b0, 5'h00, 1'b0, 2'h0)
                          | 32'hff00_807f);
        rd_reg(CTRL_ADDR, rv);
        `CHK("word ro", mk(RNG_HIGH, 5'h15, 0, 0, 0, 0) | strap, rv)
        `CHK("ratio1 reg", 5'h15, pll_ratio[1])
        `CHK("band1 high", 1'b1, pll_high_band[1])
        `CHK("loop1 run", 1'b1, pll_enable[1])
        wait_lock(1);
        switch_to(mk(RNG_HIGH, 5'h15, 1'b1, 5'h00, 1'b0, 2'h0), 1'b1);
        `CHK("core ratio 1", 5'h15, core_to_bus_ratio)
        rd_reg(CTRL_ADDR, rv);
        `CHK("status bit", 1'b1, rv[15])
        // first loop now unselected: turn it off under internal control
        wr_reg(CTRL_ADDR,
               mk(RNG_HIGH, 5'h15, 1'b1, 5'h00, 1'b1, RNG_LOW));
        wait_cyc(3);
        `CHK("loop0 off", 1'b0, pll_enable[0])
        `CHK("loop0 unlocked", 1'b0, pll_locked[0])
        // every ratio code except 4 and 5 on the unselected loop
        for (int c = 0; c < 32; c++)
        begin
            if (c == 4 || c == 5)
                continue;
            wr_reg(CTRL_ADDR,
                   mk(RNG_HIGH, 5'h15, 1'b1, c[4:0], 1'b1, 2'h0));
            wait_cyc(3);
            `CHK("decode", (c >= 4 && c <= 30), pll_enable[0])
        end
        wr_reg(CTRL_ADDR, mk(RNG_HIGH, 5'h15, 1'b1, 5'h0c, 1'b1, RNG_LOW));
        wait_cyc(2);
        `CHK("range0 reg", RNG_LOW, pll_range[0])
        wait_lock(0);
        switch_to(mk(RNG_HIGH, 5'h15, 1'b0, 5'h0c, 1'b1, RNG_LOW), 1'b0);
        // both locked: straight back and forth with no wait
        switch_to(mk(RNG_HIGH, 5'h15, 1'b1, 5'h0c, 1'b1, RNG_LOW),
                  1'b1);
        switch_to(mk(RNG_HIGH, 5'h15, 1'b0, 5'h0c, 1'b1, RNG_LOW),
                  1'b0);
        `CHK("core ratio 0", 5'h0c, core_to_bus_ratio)
        // bypass on the second loop, then select it
        wr_reg(CTRL_ADDR, mk(RNG_HIGH, CFG_BYP_LO, 1'b0, 5'h0c, 1'b1, RNG_LOW));
        wait_cyc(12);
        `CHK("bypass disabled", 1'b0, pll_enable[1])
        switch_to(mk(RNG_HIGH, CFG_BYP_LO, 1'b1, 5'h0c, 1'b1, RNG_LOW),
                  1'b1);
        `CHK("core bypass", 1'b1, core_bypass)
        `CHK("bus 1:1", 1'b1, bus_one_to_one)
        `CHK("bypass ratio", CFG_BYP_LO, core_to_bus_ratio)
        switch_to(mk(RNG_HIGH, CFG_BYP_LO, 1'b0, 5'h0c, 1'b1, RNG_LOW), 1'b0);
        `CHK("bypass cleared", 1'b0, bus_one_to_one)
        // unmapped address: writes dropped, reads give zero
        wr_reg(8'h04, 32'hffff_ffff);
        rd_reg(8'h04, rv);
        `CHK("unmapped read", 32'h0, rv)
        rd_reg(CTRL_ADDR, rv);
        `CHK("word kept", mk(RNG_HIGH, CFG_BYP_LO, 0, 5'h0c, 1, RNG_LOW) | strap,
             rv)
        // second hard reset with off straps loses all written state
        do_reset(5'h00, RNG_HIGH);
        rd_reg(CTRL_ADDR, rv);
        `CHK("reset again", 32'h0, rv)
        `CHK("clock off", 1'b1, core_clock_off)
        `CHK("gate first 2", 2'b01, core_gate)
        `CHK("status 2", 1'b0, pll_source_status)
        tally_and_finish();
    end

`undef CHK

endmodule : dpc_clock_select_bench

`default_nettype wire
